// ===== bench/acw_aux_chk.sv
// Purpose: port checker for acw_aux_ctrl
// Assumes: answers one cycle after a taken request
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module acw_aux_chk #(
    parameter int WAYS = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [0:0] req_sel_i,
    input wire logic [1:0] req_el_i,
    input wire logic [63:0] req_wdata_i,
    input wire logic el2_enabled_i,
    input wire logic impl_reg_trap_bit_i,
    input wire logic level2_aux_access_enable_i,
    input wire logic level3_aux_access_enable_i,
    input wire logic vmid_alloc_i,
    input wire logic resp_undef_o,
    input wire logic resp_trap_el2_o,
    input wire logic resp_trap_el3_o,
    input wire logic [5:0] resp_syndrome_o,
    input wire logic metadata_consumer_en_o,
    input wire logic [3:0] metadata_max_ways_o,
    input wire logic [WAYS-1:0] inst_alloc_ways_o,
    input wire logic [WAYS-1:0] data_alloc_ways_o,
    input wire logic vmid_filter_flush_o,
    input wire logic translation_prefetch_en_o
);
    // ****************************************
    // port properties
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_low_undef: assert property (ce_i && req_valid_i && req_el_i == 2'h0 |=> resp_undef_o)
        else $error("level 0 access not undefined");
    a_impl_trap: assert property (ce_i && req_valid_i && req_el_i == 2'h1 && el2_enabled_i
        && impl_reg_trap_bit_i |=> resp_trap_el2_o && resp_syndrome_o == 6'h18)
        else $error("impl trap to level 2 missing");
    a_wr_trap_two: assert property (ce_i && req_valid_i && req_write_i && req_el_i == 2'h1
        && el2_enabled_i && !level2_aux_access_enable_i |=> resp_trap_el2_o)
        else $error("level 1 write not trapped to level 2");
    a_wr_trap_three: assert property (ce_i && req_valid_i && req_write_i && req_el_i == 2'h2
        && !level3_aux_access_enable_i |=> resp_trap_el3_o && resp_syndrome_o == 6'h18)
        else $error("level 2 write not trapped to level 3");
    a_way_limit: assert property (metadata_consumer_en_o == (metadata_max_ways_o != 4'h0)
        && metadata_max_ways_o < 4'h8) else $error("metadata way limit wrong");
    a_ways_cover: assert property ((inst_alloc_ways_o | data_alloc_ways_o) == '1)
        else $error("way allocatable by nobody");
    a_flush_cause: assert property (vmid_filter_flush_o && $past(ce_i) |-> $past(vmid_alloc_i))
        else $error("flush without allocation");
    a_pf_follow: assert property (ce_i && req_valid_i && req_write_i && req_el_i == 2'h3
        && req_sel_i == 1'h1 ##1 ce_i |=> translation_prefetch_en_o == !$past(req_wdata_i[51], 2))
        else $error("prefetch enable wrong");
endmodule : acw_aux_chk
bind acw_aux_ctrl acw_aux_chk #(.WAYS(WAYS)) i_acw_aux_chk (.*);
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: directed test of acw_aux_ctrl
// Assumes: one request per two cycles
// Notes: clock enable held high except during one vmid_alloc_i run
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic [0:0] req_sel_i = 1'h0;
    logic [1:0] req_el_i = 2'h0;
    logic [63:0] req_wdata_i = 64'h0, rd, resp_rdata_o;
    logic el2_enabled_i = 1'b1, impl_reg_trap_bit_i = 1'b0, vmid_alloc_i = 1'b0;
    logic level2_aux_access_enable_i = 1'b1, level3_aux_access_enable_i = 1'b1;
    logic resp_valid_o, resp_undef_o, resp_trap_el2_o, resp_trap_el3_o, vmid_filter_flush_o;
    logic metadata_consumer_en_o, translation_prefetch_en_o;
    logic [5:0] resp_syndrome_o;
    logic [3:0] metadata_max_ways_o;
    logic [7:0] inst_alloc_ways_o, data_alloc_ways_o;
    int failures = 0, comparisons = 0, fl;
    acw_aux_ctrl i_acw_aux_ctrl (.*);
    // ****************************************
    // tasks and sequence
    // ****************************************
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // k: 0 done, 1 undefined, 2 trap to level 2, 3 trap to level 3
    task automatic acc(input logic w, s, input logic [1:0] el, input logic [63:0] wd, input int k);
        @(posedge clk_i);
        #1;
        {req_valid_i, req_write_i, req_sel_i, req_el_i, req_wdata_i} = {1'b1, w, s, el, wd};
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        rd = resp_rdata_o;
        chk({resp_valid_o, resp_undef_o, resp_trap_el2_o, resp_trap_el3_o},
            {1'b1, k == 1, k == 2, k == 3});
        chk(resp_syndrome_o, k > 1 ? 6'h18 : 6'h0);
    endtask : acc
    task automatic vm(input int n, input int exp);
        fl = 0;
        repeat (n + 3) begin
            @(posedge clk_i);
            #1;
            vmid_alloc_i = n-- > 0;
            fl += vmid_filter_flush_o;
        end
        chk(fl, exp);
    endtask : vm
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        acc(1'b0, 1'b1, 2'h3, 64'h0, 0);
        chk(rd, 64'h4000000000000000);
        chk({metadata_consumer_en_o, metadata_max_ways_o, inst_alloc_ways_o, data_alloc_ways_o,
            translation_prefetch_en_o}, {1'b1, 4'h6, 8'hff, 8'hff, 1'b1});
        acc(1'b1, 1'b1, 2'h0, 64'h0, 1);
        acc(1'b0, 1'b0, 2'h0, 64'h0, 1);
        impl_reg_trap_bit_i = 1'b1;
        acc(1'b0, 1'b0, 2'h1, 64'h0, 2);
        acc(1'b1, 1'b1, 2'h1, 64'h0, 2);
        acc(1'b0, 1'b0, 2'h2, 64'h0, 0);
        impl_reg_trap_bit_i = 1'b0;
        level2_aux_access_enable_i = 1'b0;
        acc(1'b1, 1'b0, 2'h1, 64'h1, 2);
        acc(1'b0, 1'b0, 2'h1, 64'h0, 0);
        el2_enabled_i = 1'b0;
        acc(1'b1, 1'b0, 2'h1, 64'h5, 0);
        level3_aux_access_enable_i = 1'b0;
        acc(1'b1, 1'b0, 2'h1, 64'h7, 3);
        acc(1'b1, 1'b0, 2'h2, 64'h7, 3);
        acc(1'b0, 1'b0, 2'h2, 64'h0, 0);
        chk(rd, 64'h5);
        acc(1'b1, 1'b0, 2'h3, 64'hfedcba9876543210, 0);
        acc(1'b0, 1'b0, 2'h1, 64'h0, 0);
        chk(rd, 64'hfedcba9876543210);
        {el2_enabled_i, level2_aux_access_enable_i, level3_aux_access_enable_i} = 3'h7;
        $display("access tests done");
        for (int n = 0; n < 8; n++) begin
            acc(1'b1, 1'b1, 2'h3, {n[2:0], n[2:0], 3'(7 - n), n[0], 2'h0, n[1], 51'h0}, 0);
            @(posedge clk_i);
            #1;
            chk({metadata_consumer_en_o, metadata_max_ways_o},
                {n != 0, n != 0 ? 4'(8 - n) : 4'h0});
            chk({inst_alloc_ways_o, data_alloc_ways_o},
                {8'hff << (7 - n), 8'hff >> n});
            chk(translation_prefetch_en_o, !n[1]);
        end
        vm(31, 0);
        vm(1, 1);
        acc(1'b1, 1'b1, 2'h3, 64'h4000000000000000, 0);
        vm(15, 0);
        vm(1, 1);
        ce_i = 1'b0;
        vm(20, 0);
        ce_i = 1'b1;
        vm(15, 0);
        vm(1, 1);
        $display("field tests done");
        conclude();
    end
endmodule : testbench
`default_nettype wire

// ===== design/acw_aux_ctrl.sv
// Purpose: privilege-checked auxiliary control registers and L2 way controls
// Assumes: one move request per cycle, answered on the next edge
// Notes: all outputs registered
`timescale 1ns/1ps
`default_nettype none
module acw_aux_ctrl #(
    parameter int WAYS = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [0:0] req_sel_i,
    input wire logic [1:0] req_el_i,
    input wire logic [63:0] req_wdata_i,
    input wire logic el2_enabled_i,
    input wire logic impl_reg_trap_bit_i,
    input wire logic level2_aux_access_enable_i,
    input wire logic level3_aux_access_enable_i,
    input wire logic vmid_alloc_i,
    output logic resp_valid_o,
    output logic [63:0] resp_rdata_o,
    output logic resp_undef_o,
    output logic resp_trap_el2_o,
    output logic resp_trap_el3_o,
    output logic [5:0] resp_syndrome_o,
    output logic metadata_consumer_en_o,
    output logic [3:0] metadata_max_ways_o,
    output logic [WAYS-1:0] inst_alloc_ways_o,
    output logic [WAYS-1:0] data_alloc_ways_o,
    output logic vmid_filter_flush_o,
    output logic translation_prefetch_en_o
);
    initial begin
        if (WAYS != 8) begin
            $error("acw_aux_ctrl serves eight ways only");
        end
    end
    // ****************************************
    // access decision
    // ****************************************
    typedef enum logic [3:0] {
        ACW_OK = 4'h1,
        ACW_UNDEF = 4'h2,
        ACW_TRAP2 = 4'h4,
        ACW_TRAP3 = 4'h8
    } acw_verdict_e;
    acw_verdict_e verdict;
    always_comb begin
        verdict = ACW_OK;
        unique case (req_el_i)
            acw_pkg::EL_0: begin
                verdict = ACW_UNDEF;
            end
            acw_pkg::EL_1: begin
                if (el2_enabled_i && impl_reg_trap_bit_i) begin
                    verdict = ACW_TRAP2;
                end else if (req_write_i && el2_enabled_i && !level2_aux_access_enable_i) begin
                    verdict = ACW_TRAP2;
                end else if (req_write_i && !level3_aux_access_enable_i) begin
                    verdict = ACW_TRAP3;
                end
            end
            acw_pkg::EL_2: begin
                if (req_write_i && !level3_aux_access_enable_i) begin
                    verdict = ACW_TRAP3;
                end
            end
            acw_pkg::EL_3: begin
                verdict = ACW_OK;
            end
        endcase
    end
    wire logic do_write = ce_i && req_valid_i && req_write_i && verdict == ACW_OK;
    // ****************************************
    // registers
    // ****************************************
    logic [63:0] aux_control_four_reg;
    logic [63:0] extended_cpu_control_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            aux_control_four_reg <= acw_pkg::AUX_FOUR_RST;
            extended_cpu_control_reg <= acw_pkg::EXT_CTRL_RST;
        end else if (do_write) begin
            if (req_sel_i == acw_pkg::SEL_AUX_FOUR) begin
                aux_control_four_reg <= req_wdata_i;
            end else begin
                extended_cpu_control_reg <= req_wdata_i;
            end
        end
    end
    // ****************************************
    // response
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            resp_valid_o <= 1'b0;
            resp_rdata_o <= 64'h0;
            resp_undef_o <= 1'b0;
            resp_trap_el2_o <= 1'b0;
            resp_trap_el3_o <= 1'b0;
            resp_syndrome_o <= 6'h0;
        end else if (ce_i) begin
            resp_valid_o <= req_valid_i;
            resp_undef_o <= req_valid_i && verdict == ACW_UNDEF;
            resp_trap_el2_o <= req_valid_i && verdict == ACW_TRAP2;
            resp_trap_el3_o <= req_valid_i && verdict == ACW_TRAP3;
            resp_syndrome_o <= (req_valid_i && (verdict == ACW_TRAP2 || verdict == ACW_TRAP3))
                ? acw_pkg::SYNDROME_CLASS : 6'h0;
            resp_rdata_o <= 64'h0;
            if (req_valid_i && !req_write_i && verdict == ACW_OK) begin
                resp_rdata_o <= (req_sel_i == acw_pkg::SEL_AUX_FOUR)
                    ? aux_control_four_reg : extended_cpu_control_reg;
            end
        end
    end
    // ****************************************
    // way controls
    // ****************************************
    wire logic [2:0] way_limit = extended_cpu_control_reg[acw_pkg::WAY_LIMIT_LSB +: 3];
    wire logic [2:0] inst_part = extended_cpu_control_reg[acw_pkg::INST_PART_LSB +: 3];
    wire logic [2:0] data_part = extended_cpu_control_reg[acw_pkg::DATA_PART_LSB +: 3];
    logic [WAYS-1:0] inst_ways;
    logic [WAYS-1:0] data_ways;
    acw_way_mask #(.WAYS(WAYS)) u_mask (
        .inst_part_i(inst_part),
        .data_part_i(data_part),
        .inst_ways_o(inst_ways),
        .data_ways_o(data_ways)
    );
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            metadata_consumer_en_o <= 1'b1;
            metadata_max_ways_o <= 4'h6;
            inst_alloc_ways_o <= '1;
            data_alloc_ways_o <= '1;
            translation_prefetch_en_o <= 1'b1;
        end else if (ce_i) begin
            metadata_consumer_en_o <= way_limit != 3'h0;
            metadata_max_ways_o <= (way_limit == 3'h0) ? 4'h0 : 4'h8 - {1'b0, way_limit};
            inst_alloc_ways_o <= inst_ways;
            data_alloc_ways_o <= data_ways;
            translation_prefetch_en_o <= !extended_cpu_control_reg[acw_pkg::TLBPF_OFF_BIT];
        end
    end
    // ****************************************
    // vmid filter counter
    // ****************************************
    logic [5:0] vmid_count_reg;
    wire logic [5:0] vmid_limit = extended_cpu_control_reg[acw_pkg::VMID_THR_BIT]
        ? acw_pkg::VMID_THR_HIGH : acw_pkg::VMID_THR_LOW;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            vmid_count_reg <= 6'h0;
            vmid_filter_flush_o <= 1'b0;
        end else if (ce_i) begin
            vmid_filter_flush_o <= 1'b0;
            if (vmid_alloc_i) begin
                if (vmid_count_reg + 6'h1 >= vmid_limit) begin
                    vmid_count_reg <= 6'h0;
                    vmid_filter_flush_o <= 1'b1;
                end else begin
                    vmid_count_reg <= vmid_count_reg + 6'h1;
                end
            end
        end
    end
endmodule : acw_aux_ctrl
`default_nettype wire

// ===== design/acw_pkg.sv
// Purpose: shared constants for auxiliary control access and L2 way partitioning
// Assumes: 64-bit registers reached by system-register moves
// Notes: extended control fields below bit 51 are not modelled and read as stored
package acw_pkg;
    // ****************************************
    // register selectors
    // ****************************************
    localparam logic [0:0] SEL_AUX_FOUR = 1'h0;
    localparam logic [0:0] SEL_EXT_CTRL = 1'h1;
    // ****************************************
    // exception levels
    // ****************************************
    localparam logic [1:0] EL_0 = 2'h0;
    localparam logic [1:0] EL_1 = 2'h1;
    localparam logic [1:0] EL_2 = 2'h2;
    localparam logic [1:0] EL_3 = 2'h3;
    localparam logic [5:0] SYNDROME_CLASS = 6'h18;
    // ****************************************
    // extended control field positions
    // ****************************************
    localparam int WAY_LIMIT_LSB = 61;
    localparam int INST_PART_LSB = 58;
    localparam int DATA_PART_LSB = 55;
    localparam int VMID_THR_BIT = 54;
    localparam int TLBPF_OFF_BIT = 51;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] WAY_LIMIT_RST = 3'h2;
    localparam logic [2:0] INST_PART_RST = 3'h0;
    localparam logic [2:0] DATA_PART_RST = 3'h0;
    localparam logic [63:0] AUX_FOUR_RST = 64'h0;
    localparam logic [63:0] EXT_CTRL_RST = {WAY_LIMIT_RST, INST_PART_RST, DATA_PART_RST, 55'h0};
    // ****************************************
    // vmid filter thresholds
    // ****************************************
    localparam logic [5:0] VMID_THR_LOW = 6'h10;
    localparam logic [5:0] VMID_THR_HIGH = 6'h20;
endpackage : acw_pkg

// ===== design/acw_way_mask.sv
// Purpose: per-way allocation masks from the partition fields
// Assumes: eight ways, way 7 the highest
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module acw_way_mask #(
    parameter int WAYS = 8
) (
    input wire logic [2:0] inst_part_i,
    input wire logic [2:0] data_part_i,
    output logic [WAYS-1:0] inst_ways_o,
    output logic [WAYS-1:0] data_ways_o
);
    initial begin
        if (WAYS != 8) begin
            $error("acw_way_mask serves eight ways only");
        end
    end
    always_comb begin
        for (int w = 0; w < WAYS; w++) begin
            // every way open to both unless a partition claims it
            inst_ways_o[w] = 1'b1;
            data_ways_o[w] = 1'b1;
            // low n ways for data only, top n ways for fetches only
            if (data_part_i != 3'h0 && w < int'(data_part_i)) begin
                inst_ways_o[w] = 1'b0;
            end
            if (inst_part_i != 3'h0 && w >= WAYS - int'(inst_part_i)) begin
                data_ways_o[w] = 1'b0;
            end
        end
    end
endmodule : acw_way_mask
`default_nettype wire
